// ### logic/sbr_pkg.sv
// Shared constants and types for the SMBus block register port and its controller.
package sbr_pkg;
  localparam logic [7:0] WRITE_ADDR = 8'hD2;
  localparam logic [7:0] READ_ADDR = 8'hD3;
  localparam int REG_COUNT = 9;
  localparam logic [3:0] COUNT_IDX = 4'h8;
  localparam logic [7:0] CTL0_RST = 8'h3E;
  localparam logic [7:0] COUNT_RST = 8'h09;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam int BIT_LINK_STRAP = 7;
  localparam int BIT_STORAGE_STRAP = 6;
  localparam int BIT_REF0 = 5;
  localparam int BIT_REF1 = 4;
  localparam int BIT_REF2 = 3;
  localparam int BIT_USB1 = 2;
  localparam int BIT_USB0 = 1;
  localparam int BIT_SPREAD = 0;
  localparam int CLK_MHZ = 200;
  localparam int SCL_QUARTER_NS = 500;
  localparam logic [9:0] SCL_QUARTER_CYC = 10'(SCL_QUARTER_NS * CLK_MHZ / 1000);
  localparam int AXI_ADDR_W = 5;
  localparam logic [4:0] OFF_CMD = 5'h00;
  localparam logic [4:0] OFF_WDATA = 5'h04;
  localparam logic [4:0] OFF_STATUS = 5'h08;
  localparam logic [4:0] OFF_RDATA = 5'h0C;
  localparam int CMD_CNT_LSB = 8;
  localparam int CMD_READ_BIT = 12;
  localparam int CMD_GO_BIT = 31;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_NACK_BIT = 1;
  localparam int STAT_COUNT_LSB = 8;
  localparam logic [2:0] RX_KEEP = 3'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {ROLE_INDEX = 3'h1, ROLE_COUNT = 3'h2, ROLE_DATA = 3'h4} sbr_role_t;
  typedef enum logic [5:0] {
    D_IDLE = 6'h01, D_ADDR = 6'h02, D_ACK = 6'h04, D_WRX = 6'h08, D_TX = 6'h10, D_RACK = 6'h20
  } sbr_dev_state_t;
  typedef enum logic [3:0] {L_IDLE = 4'h1, L_START = 4'h2, L_XFER = 4'h4, L_STOP = 4'h8} sbr_lvl_t;
  typedef enum logic [6:0] {
    S_ADDRW = 7'h01, S_INDEX = 7'h02, S_COUNT = 7'h04, S_WDATA = 7'h08,
    S_ADDRR = 7'h10, S_RCOUNT = 7'h20, S_RDATA = 7'h40
  } sbr_step_t;
endpackage

// ### logic/sbr_link_if.sv
// Two-wire serial link between the controller and the register port, with open-drain resolution.
`timescale 1ns/1ps
interface sbr_link_if;
  logic scl_out;
  logic scl_oe;
  logic sda_h_out;
  logic sda_h_oe;
  logic sda_d_out;
  logic sda_d_oe;
  logic scl;
  logic sda;
  // Both lines are pulled high unless an enabled driver pulls them low.
  assign scl = (scl_oe && !scl_out) ? 1'b0 : 1'b1;
  assign sda = ((sda_h_oe && !sda_h_out) || (sda_d_oe && !sda_d_out)) ? 1'b0 : 1'b1;
  modport host(output scl_out, output scl_oe, output sda_h_out, output sda_h_oe, input sda);
  modport device(output sda_d_out, output sda_d_oe, input scl, input sda);
endinterface

// ### logic/sbr_device.sv
// SMBus target port with indexed block write and block read over the control bytes.
//
// Function
// - Host opens writes with start, address D2.
// - Index byte acknowledged, sets first location.
// - Write count byte acknowledged before data.
// - Each data byte acknowledged, stored only at locations zero to eight.
// - Host ends block write with stop.
// - Read starts with index write, repeated start.
// - Read address D3 acknowledged before data.
// - Read returns count, then ascending bytes.
// - Count returned comes from byte eight.
// - Host acknowledges all but final byte.
// - Host answers final byte with not-acknowledge.
// - Host ends read with stop.
// - Byte zero top bits are latched straps.
// - Byte zero enables reference and USB outputs.
// - Byte zero bit zero enables spreading.
`timescale 1ns/1ps
module sbr_device
  import sbr_pkg::*;
(
  input wire logic LINK_CLK,
  input wire logic LINK_RST,
  input wire logic LINK_CLOCK_TYPE_STRAP,
  input wire logic STORAGE_PAIR_MODE_STRAP,
  output logic REFERENCE_OUT0_ENABLE,
  output logic REFERENCE_OUT1_ENABLE,
  output logic REFERENCE_OUT2_ENABLE,
  output logic USB_CLOCK1_ENABLE,
  output logic USB_CLOCK0_ENABLE,
  output logic SPREAD_ENABLE,
  sbr_link_if.device LINK
);
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic [1:0] link_strap_sync;
  logic [1:0] pair_strap_sync;
  logic scl_prev;
  logic sda_prev;
  logic start_c;
  logic stop_c;
  logic rise_c;
  logic fall_c;
  logic byte_done_c;
  logic store_c;
  logic [7:0] rx_c;
  logic [7:0] next_tx;
  sbr_dev_state_t state;
  sbr_role_t role;
  logic [3:0] bitn;
  logic [7:0] sh;
  logic [7:0] txsh;
  logic [7:0] ptr;
  logic reading;
  logic first;
  logic acked;
  logic host_ack;
  logic drive_low;
  logic strap_done;
  logic [1:0] strap_age;
  logic [7:0] regs [0:REG_COUNT-1];

  function automatic logic [7:0] read_byte(input logic [7:0] idx);
    if (idx < 8'(REG_COUNT)) begin
      return regs[idx[3:0]];
    end
    return BYTE_RST;
  endfunction

  // The pins and straps come from outside this clock domain.
  always_ff @(posedge LINK_CLK) begin
    if (LINK_RST) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      link_strap_sync <= 2'h0;
      pair_strap_sync <= 2'h0;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], LINK.scl};
      sda_sync <= {sda_sync[0], LINK.sda};
      link_strap_sync <= {link_strap_sync[0], LINK_CLOCK_TYPE_STRAP};
      pair_strap_sync <= {pair_strap_sync[0], STORAGE_PAIR_MODE_STRAP};
      scl_prev <= scl_sync[1];
      sda_prev <= sda_sync[1];
    end
  end

  assign start_c = scl_sync[1] && scl_prev && sda_prev && !sda_sync[1];
  assign stop_c = scl_sync[1] && scl_prev && !sda_prev && sda_sync[1];
  assign rise_c = scl_sync[1] && !scl_prev;
  assign fall_c = !scl_sync[1] && scl_prev;
  assign rx_c = {sh[6:0], sda_sync[1]};
  assign byte_done_c = rise_c && (bitn == 4'h7);
  assign store_c = (state == D_WRX) && byte_done_c && (role == ROLE_DATA);
  // The first byte of a read is the programmed count, not a location.
  assign next_tx = first ? regs[COUNT_IDX] : read_byte(ptr);

  always_ff @(posedge LINK_CLK) begin
    if (LINK_RST) begin
      state <= D_IDLE;
      role <= ROLE_INDEX;
      bitn <= 4'h0;
      sh <= 8'h00;
      txsh <= 8'h00;
      ptr <= 8'h00;
      reading <= 1'b0;
      first <= 1'b0;
      acked <= 1'b0;
      host_ack <= 1'b1;
      drive_low <= 1'b0;
    end else if (stop_c) begin
      state <= D_IDLE;
      drive_low <= 1'b0;
    end else if (start_c) begin
      // A repeated start lands here too and restarts address decoding.
      state <= D_ADDR;
      bitn <= 4'h0;
      drive_low <= 1'b0;
    end else begin
      case (state)
        D_ADDR: begin
          if (rise_c) begin
            sh <= rx_c;
            bitn <= bitn + 4'h1;
          end
          if (byte_done_c) begin
            acked <= 1'b0;
            if (rx_c == WRITE_ADDR) begin
              state <= D_ACK;
              reading <= 1'b0;
              role <= ROLE_INDEX;
            end else if (rx_c == READ_ADDR) begin
              state <= D_ACK;
              reading <= 1'b1;
              first <= 1'b1;
            end else begin
              state <= D_IDLE;
            end
          end
        end
        D_WRX: begin
          if (rise_c) begin
            sh <= rx_c;
            bitn <= bitn + 4'h1;
          end
          if (byte_done_c) begin
            state <= D_ACK;
            acked <= 1'b0;
            case (role)
              ROLE_INDEX: begin
                ptr <= rx_c;
                role <= ROLE_COUNT;
              end
              ROLE_COUNT: begin
                role <= ROLE_DATA;
              end
              default: begin
                ptr <= ptr + 8'h01;
              end
            endcase
          end
        end
        D_ACK: begin
          if (fall_c && !acked) begin
            drive_low <= 1'b1;
            acked <= 1'b1;
          end else if (fall_c) begin
            acked <= 1'b0;
            bitn <= 4'h0;
            if (reading) begin
              state <= D_TX;
              txsh <= next_tx;
              drive_low <= !next_tx[7];
              first <= 1'b0;
              if (!first) begin
                ptr <= ptr + 8'h01;
              end
            end else begin
              state <= D_WRX;
              drive_low <= 1'b0;
            end
          end
        end
        D_TX: begin
          if (rise_c) begin
            bitn <= bitn + 4'h1;
          end
          if (fall_c && (bitn == 4'h8)) begin
            state <= D_RACK;
            drive_low <= 1'b0;
          end else if (fall_c) begin
            txsh <= {txsh[6:0], 1'b0};
            drive_low <= !txsh[6];
          end
        end
        D_RACK: begin
          if (rise_c) begin
            host_ack <= sda_sync[1];
          end
          if (fall_c && !host_ack) begin
            state <= D_TX;
            bitn <= 4'h0;
            txsh <= next_tx;
            drive_low <= !next_tx[7];
            ptr <= ptr + 8'h01;
          end else if (fall_c) begin
            state <= D_IDLE;
          end
        end
        default: begin
          drive_low <= 1'b0;
        end
      endcase
    end
  end

  // Straps are caught once, on the third clock after reset is released, when the
  // synchroniser has flushed its reset value and holds the real strap level.
  always_ff @(posedge LINK_CLK) begin
    if (LINK_RST) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs[i] <= BYTE_RST;
      end
      regs[0] <= CTL0_RST;
      regs[COUNT_IDX] <= COUNT_RST;
      strap_done <= 1'b0;
      strap_age <= 2'h0;
    end else begin
      strap_age <= {strap_age[0], 1'b1};
      if (!strap_done && (strap_age == 2'h3)) begin
        regs[0][BIT_LINK_STRAP] <= link_strap_sync[1];
        regs[0][BIT_STORAGE_STRAP] <= pair_strap_sync[1];
        strap_done <= 1'b1;
      end
      if (store_c && (ptr == 8'h00)) begin
        regs[0][BIT_REF0:0] <= rx_c[BIT_REF0:0];
      end else if (store_c && (ptr < 8'(REG_COUNT))) begin
        regs[ptr[3:0]] <= rx_c;
      end
    end
  end

  assign REFERENCE_OUT0_ENABLE = regs[0][BIT_REF0];
  assign REFERENCE_OUT1_ENABLE = regs[0][BIT_REF1];
  assign REFERENCE_OUT2_ENABLE = regs[0][BIT_REF2];
  assign USB_CLOCK1_ENABLE = regs[0][BIT_USB1];
  assign USB_CLOCK0_ENABLE = regs[0][BIT_USB0];
  assign SPREAD_ENABLE = regs[0][BIT_SPREAD];
  assign LINK.sda_d_out = 1'b0;
  assign LINK.sda_d_oe = drive_low;
endmodule

// ### logic/sbr_host.sv
// SMBus controller that runs indexed block writes and reads, ordered over AXI4-Lite.
`timescale 1ns/1ps
module sbr_host
  import sbr_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic [AXI_ADDR_W-1:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [AXI_ADDR_W-1:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  sbr_link_if.host LINK
);
  logic aw_got;
  logic w_got;
  logic [4:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [7:0] cmd_index;
  logic [2:0] cmd_cnt;
  logic cmd_read;
  logic [31:0] wbytes;
  logic go;
  logic busy;
  logic nack;
  logic [7:0] rx_count;
  logic [31:0] rbytes;
  logic [1:0] sda_sync;
  logic [9:0] qcnt;
  logic tick;
  sbr_lvl_t lvl;
  sbr_step_t step;
  logic [1:0] ph;
  logic [3:0] bitn;
  logic [8:0] tsh;
  logic [8:0] rsh;
  logic [7:0] left;
  logic [1:0] widx;
  logic [2:0] ridx;
  logic rcv;
  logic txbit;
  logic scl_low;
  logic sda_low;

  function automatic logic [2:0] reg_sel(input logic [4:0] a);
    if (a == OFF_CMD) begin
      return 3'h4;
    end else if (a == OFF_WDATA) begin
      return 3'h5;
    end else if (a == OFF_STATUS) begin
      return 3'h6;
    end else if (a == OFF_RDATA) begin
      return 3'h7;
    end
    return 3'h0;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int k = 0; k < 4; k++) begin
      if (st[k]) begin
        r[8*k +: 8] = nw[8*k +: 8];
      end
    end
    return r;
  endfunction

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      AWREADY <= 1'b0;
      WREADY <= 1'b0;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 5'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      BVALID <= 1'b0;
      BRESP <= RESP_OKAY;
      cmd_index <= 8'h00;
      cmd_cnt <= 3'h0;
      cmd_read <= 1'b0;
      wbytes <= 32'h00000000;
      go <= 1'b0;
    end else begin
      go <= 1'b0;
      if (AWVALID && AWREADY) begin
        AWREADY <= 1'b0;
        aw_got <= 1'b1;
        aw_addr <= AWADDR;
      end else if (!aw_got && !BVALID) begin
        AWREADY <= 1'b1;
      end
      if (WVALID && WREADY) begin
        WREADY <= 1'b0;
        w_got <= 1'b1;
        w_data <= WDATA;
        w_strb <= WSTRB;
      end else if (!w_got && !BVALID) begin
        WREADY <= 1'b1;
      end
      if (aw_got && w_got && !BVALID) begin
        BVALID <= 1'b1;
        BRESP <= (reg_sel(aw_addr) != 3'h0) ? RESP_OKAY : RESP_SLVERR;
        if (reg_sel(aw_addr) == 3'h4) begin
          if (w_strb[0]) begin
            cmd_index <= w_data[7:0];
          end
          if (w_strb[1]) begin
            cmd_cnt <= w_data[CMD_CNT_LSB +: 3];
            cmd_read <= w_data[CMD_READ_BIT];
          end
          // A go request while a transfer runs is dropped.
          go <= w_strb[3] && w_data[CMD_GO_BIT] && !busy;
        end else if (reg_sel(aw_addr) == 3'h5) begin
          wbytes <= merge(wbytes, w_data, w_strb);
        end
      end
      if (BVALID && BREADY) begin
        BVALID <= 1'b0;
        aw_got <= 1'b0;
        w_got <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ARREADY <= 1'b0;
      RVALID <= 1'b0;
      RDATA <= 32'h00000000;
      RRESP <= RESP_OKAY;
    end else if (ARVALID && ARREADY) begin
      ARREADY <= 1'b0;
      RVALID <= 1'b1;
      RRESP <= (reg_sel(ARADDR) != 3'h0) ? RESP_OKAY : RESP_SLVERR;
      case (reg_sel(ARADDR))
        3'h4: RDATA <= {19'h00000, cmd_read, 1'b0, cmd_cnt, cmd_index};
        3'h5: RDATA <= wbytes;
        3'h6: RDATA <= {16'h0000, rx_count, 6'h00, nack, busy};
        3'h7: RDATA <= rbytes;
        default: RDATA <= 32'h00000000;
      endcase
    end else if (RVALID && RREADY) begin
      RVALID <= 1'b0;
    end else if (!RVALID) begin
      ARREADY <= 1'b1;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      sda_sync <= 2'h3;
      qcnt <= 10'h000;
    end else begin
      sda_sync <= {sda_sync[0], LINK.sda};
      qcnt <= (lvl == L_IDLE || tick) ? 10'h000 : qcnt + 10'h001;
    end
  end

  assign tick = (qcnt == SCL_QUARTER_CYC - 10'h001);
  assign rcv = (step == S_RCOUNT) || (step == S_RDATA);
  // On the ninth bit of a received byte the controller answers: the count byte is
  // acknowledged unless it is zero, data unless it is the last one.
  always_comb begin
    txbit = tsh[8];
    if (rcv && bitn == 4'h8) begin
      txbit = (step == S_RCOUNT) ? (rsh[7:0] == 8'h00) : (left == 8'h01);
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      lvl <= L_IDLE;
      step <= S_ADDRW;
      ph <= 2'h0;
      bitn <= 4'h0;
      tsh <= 9'h1FF;
      rsh <= 9'h000;
      left <= 8'h00;
      widx <= 2'h0;
      ridx <= 3'h0;
      busy <= 1'b0;
      nack <= 1'b0;
      rx_count <= 8'h00;
      rbytes <= 32'h00000000;
      scl_low <= 1'b0;
      sda_low <= 1'b0;
    end else if (lvl == L_IDLE) begin
      if (go) begin
        lvl <= L_START;
        step <= S_ADDRW;
        ph <= 2'h0;
        busy <= 1'b1;
        nack <= 1'b0;
        rx_count <= 8'h00;
        ridx <= 3'h0;
      end
    end else if (tick) begin
      ph <= ph + 2'h1;
      case (lvl)
        L_START: begin
          case (ph)
            2'h0: begin
              scl_low <= 1'b1;
              sda_low <= 1'b0;
            end
            2'h1: scl_low <= 1'b0;
            2'h2: sda_low <= 1'b1;
            default: begin
              scl_low <= 1'b1;
              lvl <= L_XFER;
              bitn <= 4'h0;
              tsh <= {(step == S_ADDRR) ? READ_ADDR : WRITE_ADDR, 1'b1};
            end
          endcase
        end
        L_XFER: begin
          case (ph)
            2'h0: sda_low <= !txbit;
            2'h1: scl_low <= 1'b0;
            2'h2: rsh <= {rsh[7:0], sda_sync[1]};
            default: begin
              scl_low <= 1'b1;
              tsh <= {tsh[7:0], 1'b1};
              bitn <= bitn + 4'h1;
              if (bitn == 4'h8) begin
                bitn <= 4'h0;
                if (!rcv && rsh[0]) begin
                  nack <= 1'b1;
                  lvl <= L_STOP;
                end else begin
                  case (step)
                    S_ADDRW: begin
                      step <= S_INDEX;
                      tsh <= {cmd_index, 1'b1};
                    end
                    S_INDEX: begin
                      if (cmd_read) begin
                        step <= S_ADDRR;
                        lvl <= L_START;
                      end else begin
                        step <= S_COUNT;
                        tsh <= {5'h00, cmd_cnt, 1'b1};
                      end
                    end
                    S_COUNT: begin
                      step <= S_WDATA;
                      left <= {5'h00, cmd_cnt};
                      widx <= 2'h1;
                      tsh <= {wbytes[7:0], 1'b1};
                      if (cmd_cnt == 3'h0) begin
                        lvl <= L_STOP;
                      end
                    end
                    S_WDATA: begin
                      left <= left - 8'h01;
                      widx <= widx + 2'h1;
                      tsh <= {wbytes[8*widx +: 8], 1'b1};
                      if (left == 8'h01) begin
                        lvl <= L_STOP;
                      end
                    end
                    S_ADDRR: begin
                      step <= S_RCOUNT;
                      tsh <= 9'h1FF;
                    end
                    S_RCOUNT: begin
                      step <= S_RDATA;
                      rx_count <= rsh[8:1];
                      left <= rsh[8:1];
                      if (rsh[8:1] == 8'h00) begin
                        lvl <= L_STOP;
                      end
                    end
                    default: begin
                      if (ridx < RX_KEEP) begin
                        rbytes[8*ridx[1:0] +: 8] <= rsh[8:1];
                        ridx <= ridx + 3'h1;
                      end
                      left <= left - 8'h01;
                      if (left == 8'h01) begin
                        lvl <= L_STOP;
                      end
                    end
                  endcase
                end
              end
            end
          endcase
        end
        default: begin
          case (ph)
            2'h0: sda_low <= 1'b1;
            2'h1: scl_low <= 1'b0;
            2'h2: sda_low <= 1'b0;
            default: begin
              lvl <= L_IDLE;
              busy <= 1'b0;
            end
          endcase
        end
      endcase
    end
  end

  assign LINK.scl_out = 1'b0;
  assign LINK.scl_oe = scl_low;
  assign LINK.sda_h_out = 1'b0;
  assign LINK.sda_h_oe = sda_low;
endmodule

// ### tb/sbr_link_asserts.sv
// Concurrent checks on the serial link between the controller and the register port.
`timescale 1ns/1ps
module sbr_link_asserts
  import sbr_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_h_out,
  input wire logic sda_h_oe,
  input wire logic sda_d_out,
  input wire logic sda_d_oe,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);
  logic [3:0] nbit;
  logic [7:0] shreg;
  logic first;
  logic wr;
  logic idle;
  logic [11:0] hcnt;
  // A repeated start restarts the count, so the byte after it is an address again.
  always_ff @(posedge CLOCK) begin
    if (RST || (scl && $fell(sda))) begin
      nbit <= 4'h0;
      first <= !RST;
    end else if ($rose(scl)) begin
      nbit <= (nbit == 4'h9) ? 4'h1 : nbit + 4'h1;
      shreg <= {shreg[6:0], sda};
      if (nbit == 4'h9) begin
        first <= 1'b0;
      end
    end
  end
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      wr <= 1'b0;
    end else if ($rose(scl) && first && nbit == 4'h8) begin
      wr <= (shreg == WRITE_ADDR);
    end
  end
  always_ff @(posedge CLOCK) begin
    if (RST || (scl && $rose(sda))) begin
      idle <= 1'b1;
    end else if (scl && $fell(sda)) begin
      idle <= 1'b0;
    end
  end
  always_ff @(posedge CLOCK) begin
    if (RST || !scl) begin
      hcnt <= 12'h000;
    end else if (hcnt != 12'hFFF) begin
      hcnt <= hcnt + 12'h001;
    end
  end
  sequence start_s;
    scl && $fell(sda);
  endsequence
  sequence addr_ack_s;
    $rose(scl) && first && nbit == 4'h8;
  endsequence
  sequence data_ack_s;
    $rose(scl) && wr && !first && nbit == 4'h8;
  endsequence
  addr_ack_a:
    assert property (addr_ack_s |-> sda == !(shreg == WRITE_ADDR || shreg == READ_ADDR))
    else $error("address acknowledge wrong");
  write_ack_a:
    assert property (data_ack_s |-> !sda)
    else $error("write byte not acknowledged");
  dev_grab_a:
    assert property ($rose(sda_d_oe) |-> !scl)
    else $error("port took data line while clock high");
  dev_release_a:
    assert property ($fell(sda_d_oe) |-> !scl)
    else $error("port released data line while clock high");
  idle_release_a:
    assert property (idle |-> !sda_d_oe)
    else $error("port drives data line outside a frame");
  start_frame_a:
    assert property (start_s |-> ##[1:1000] !scl)
    else $error("clock not pulled low after start");
  clock_high_a:
    assert property ($fell(scl) |-> hcnt >= {2'h0, SCL_QUARTER_CYC})
    else $error("clock high phase too short");
  open_drain_a:
    assert property (!scl_out && !sda_h_out && !sda_d_out)
    else $error("line driven high");
endmodule

// ### tb/tb.sv
// Self-checking bench: controller and register port joined over the serial link.
`timescale 1ns/1ps
module tb;
  import sbr_pkg::*;
  logic clock = 1'b0;
  logic link_clk = 1'b0;
  logic rst = 1'b1;
  logic link_rst = 1'b1;
  logic [4:0] awaddr = 5'h00;
  logic [4:0] araddr = 5'h00;
  logic [31:0] wdata = 32'h00000000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, rd;
  logic [1:0] resp;
  logic ref0, ref1, ref2, usb1, usb0, spread;
  int errors = 0;
  int samples_checked = 0;
  always #2.5 clock = ~clock;
  // The offset keeps link edges from landing on controller clock edges.
  initial begin
    #0.7;
    forever #62.5 link_clk = ~link_clk;
  end
  initial begin
    repeat (20) @(posedge link_clk);
    link_rst <= 1'b0;
  end
  sbr_link_if sbr_link_if_inst ();
  sbr_host sbr_host_inst (.CLOCK(clock), .RST(rst), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(4'hF), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
    .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
    .RVALID(rvalid), .RREADY(rready), .LINK(sbr_link_if_inst));
  sbr_device sbr_device_inst (.LINK_CLK(link_clk), .LINK_RST(link_rst), .LINK_CLOCK_TYPE_STRAP(1'b1),
    .STORAGE_PAIR_MODE_STRAP(1'b0), .REFERENCE_OUT0_ENABLE(ref0), .REFERENCE_OUT1_ENABLE(ref1),
    .REFERENCE_OUT2_ENABLE(ref2), .USB_CLOCK1_ENABLE(usb1), .USB_CLOCK0_ENABLE(usb0),
    .SPREAD_ENABLE(spread), .LINK(sbr_link_if_inst));
  sbr_link_asserts sbr_link_asserts_inst (.CLOCK(clock), .RST(rst), .scl_out(sbr_link_if_inst.scl_out),
    .scl_oe(sbr_link_if_inst.scl_oe), .sda_h_out(sbr_link_if_inst.sda_h_out),
    .sda_h_oe(sbr_link_if_inst.sda_h_oe), .sda_d_out(sbr_link_if_inst.sda_d_out),
    .sda_d_oe(sbr_link_if_inst.sda_d_oe), .scl(sbr_link_if_inst.scl), .sda(sbr_link_if_inst.sda));
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic timed_out();
    errors++;
    complete_run();
  endtask
  task automatic axi_write(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge clock);
      if (awready) begin
        awvalid <= 1'b0;
      end
      if (wready) begin
        wvalid <= 1'b0;
      end
      if (bvalid) begin
        bready <= 1'b0;
        r = bresp;
        done = 1'b1;
      end
      n++;
      if (n > 100) begin
        timed_out();
      end
    end
    @(posedge clock);
  endtask
  task automatic axi_read(input logic [4:0] a, output logic [31:0] d);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge clock);
      if (arready) begin
        arvalid <= 1'b0;
      end
      if (rvalid) begin
        rready <= 1'b0;
        d = rdata;
        done = 1'b1;
      end
      n++;
      if (n > 100) begin
        timed_out();
      end
    end
    @(posedge clock);
  endtask
  // A frame lasts about a hundred microseconds, so status is polled sparsely to keep the bus quiet.
  task automatic run_frame(input logic [31:0] cmd);
    int n;
    n = 0;
    axi_write(OFF_CMD, cmd, resp);
    do begin
      repeat (200) @(posedge clock);
      axi_read(OFF_STATUS, rd);
      n++;
      if (n > 150) begin
        timed_out();
      end
    end while (rd[STAT_BUSY_BIT] !== 1'b0);
  endtask
  initial begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    repeat (800) @(posedge clock);
    check("outputs at reset", {26'h0, ref0, ref1, ref2, usb1, usb0, spread}, 32'h3E);
    axi_write(5'h10, 32'h0, resp);
    check("unmapped bresp", {30'h0, resp}, {30'h0, RESP_SLVERR});
    axi_write(OFF_WDATA, 32'h0000A5D5, resp);
    check("wdata bresp", {30'h0, resp}, {30'h0, RESP_OKAY});
    run_frame(32'h80000200);
    check("write status", {30'h0, rd[1:0]}, 32'h0);
    check("outputs after write", {26'h0, ref0, ref1, ref2, usb1, usb0, spread}, 32'h15);
    axi_write(OFF_WDATA, 32'h00000002, resp);
    run_frame(32'h80000108);
    check("count write status", {30'h0, rd[1:0]}, 32'h0);
    run_frame(32'h80001000);
    check("read status", {16'h0, rd[15:0]}, 32'h0200);
    axi_read(OFF_RDATA, rd);
    check("read bytes", {16'h0, rd[15:0]}, 32'hA595);
    check("rdata rresp", {30'h0, rresp}, {30'h0, RESP_OKAY});
    complete_run();
  end
endmodule
